// [design/timer8_wave.sv]
// Purpose: 8-bit timer with normal, clear-on-compare and two PWM modes.
// Assumes: One clock, synchronous active-low reset, AXI4-Lite registers.
// Notes: The prescaler and an external count pin are included here.
//
// Contract
// - Output mode zero leaves the output bit untouched on compare match.
// - New output mode acts at next match; force strobe acts at once in normal and clear-on-compare modes, none in PWM.
// - Count sequence follows wave mode only; output mode picks action.
// - Normal mode counts up, wraps 0xFF to 0x00, software may load.
// - Normal mode sets overflow as count becomes zero; only sets.
// - Clear-on-compare mode (2) clears the counter on compare match.
// - Clear-on-compare compare value unbuffered; low value waits for wrap.
// - Clear-on-compare output mode 1 toggles output on every match.
// - Clear-on-compare sets overflow as counter passes max to zero.
// - Fast PWM (3) counts bottom to max, clears on next tick.
// - Fast PWM sets overflow each time counter reaches max.
// - Fast PWM mode 2 clears on match, sets at wrap; 3 inverts.
// - Fast PWM bottom compare gives spike; max compare gives constant.
// - Fast PWM mode 1 toggles on match; compare stays double buffered.
// - Phase PWM (1) counts up then down; max holds one tick.
// - Phase PWM mode 2 clears on up match, sets on down.
// - Phase PWM sets overflow each time counter reaches bottom.
// - Phase PWM bottom compare gives low, max gives high, non-inverted.
// - Phase PWM output may change at top without match, for symmetry.
// - Phase PWM resolution is fixed to the full 8 bits.
// - Timer tick is clock divided by 1, 8, 64, 256 or 1024, or a rising or falling edge of the count pin.
// - Compare value buffered in PWM modes, immediate otherwise.
// - Compare flag sets on the tick after count equals compare.
// - Forced compare moves output only; no flag, no counter change.
// - Reset clears the output compare bit.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps

module timer8_wave (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// AXI4-Lite write channels.
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// External count pin.
	input wire logic ext_count_pin,
	// Waveform and flags.
	output logic cmp_out_pin,
	output logic cmp_out_en,
	output logic overflow_flag,
	output logic cmp_match_flag
);

	////////////////////////////////////////////////////////////////////////
	// Register state.
	timer8_pkg::ctrl_t ctrl_reg;
	logic [7:0] count_value_reg;
	logic [7:0] cmp_value_reg;
	logic [7:0] cmp_act_reg;
	logic cmp_out_bit;
	logic dir_up_reg;
	logic up_hit_reg;
	logic block_reg;
	logic [9:0] pre_reg;
	logic [2:0] ext_sync_reg;

	logic [3:0] aw_addr_reg;
	logic aw_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_have_reg;
	logic do_write;
	logic wr_ctrl;
	logic wr_count;
	logic wr_cmp;
	logic wr_stat;
	logic force_cmp_strobe;
	logic tick;
	logic is_pwm;

	// Byte offset of the addressed word, kept to the low nibble.
	function automatic logic [3:0] word_ofs(input logic [31:0] a);
		word_ofs = {a[3:2], 2'b00};
	endfunction

	function automatic logic mapped(input logic [31:0] a);
		mapped = (a[31:4] == 28'h000_0000);
	endfunction

	// Compare action on the output bit for the given mode and direction.
	function automatic logic wave_action(input logic cur, input logic [1:0] com,
			input timer8_pkg::wave_mode_t m, input logic up);
		logic r;
		r = cur;
		if (m == timer8_pkg::WAVE_PHASE) begin
			if (com[1]) begin
				r = up ? com[0] : ~com[0];
			end
		end else begin
			case (com)
				2'b01: r = ~cur;
				2'b10: r = 1'b0;
				2'b11: r = 1'b1;
				default: r = cur;
			endcase
		end
		wave_action = r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave.
	assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign wr_ctrl = do_write && aw_addr_reg == timer8_pkg::OFS_CTRL &&
		w_strb_reg[0];
	assign wr_count = do_write && aw_addr_reg == timer8_pkg::OFS_COUNT &&
		w_strb_reg[0];
	assign wr_cmp = do_write && aw_addr_reg == timer8_pkg::OFS_CMP &&
		w_strb_reg[0];
	assign wr_stat = do_write && aw_addr_reg == timer8_pkg::OFS_STATUS &&
		w_strb_reg[0];
	assign force_cmp_strobe = wr_ctrl &&
		w_data_reg[timer8_pkg::CTRL_FORCE_BIT];

	always_ff @(posedge clk) begin
		if (!rstn) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_reg <= 1'b1;
			aw_addr_reg <= mapped(s_axi_awaddr) ?
				word_ofs(s_axi_awaddr) : 4'h3;
			s_axi_awready <= 1'b0;
		end else if (do_write) begin
			aw_have_reg <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_reg && !s_axi_bvalid;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (do_write) begin
			w_have_reg <= 1'b0;
		end else begin
			s_axi_wready <= !w_have_reg && !s_axi_bvalid;
		end
	end

	// Unmapped addresses were folded to a non-aligned index, answered SLVERR.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= timer8_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_reg[1:0] != 2'b00) ?
				timer8_pkg::RESP_SLVERR : timer8_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= timer8_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= timer8_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			if (!mapped(s_axi_araddr)) begin
				s_axi_rresp <= timer8_pkg::RESP_SLVERR;
			end else begin
				case (word_ofs(s_axi_araddr))
					// The force bit always reads back as zero.
					timer8_pkg::OFS_CTRL: s_axi_rdata[6:0] <= ctrl_reg;
					timer8_pkg::OFS_COUNT: s_axi_rdata[7:0] <= count_value_reg;
					timer8_pkg::OFS_CMP: s_axi_rdata[7:0] <= cmp_value_reg;
					timer8_pkg::OFS_STATUS: s_axi_rdata[2:0] <=
						{cmp_out_bit, cmp_match_flag, overflow_flag};
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_reg <= timer8_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_reg <= timer8_pkg::ctrl_t'(w_data_reg[6:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer tick. The pin is sampled by three flops; the last two decide.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ext_sync_reg <= 3'b000;
			pre_reg <= 10'h000;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], ext_count_pin};
			pre_reg <= pre_reg + 10'h001;
		end
	end

	always_comb begin
		case (ctrl_reg.clk_sel)
			timer8_pkg::CLK_DIV1: tick = 1'b1;
			timer8_pkg::CLK_DIV8: tick = (pre_reg & timer8_pkg::DIV8_MASK) ==
				timer8_pkg::DIV8_MASK;
			timer8_pkg::CLK_DIV64: tick = (pre_reg & timer8_pkg::DIV64_MASK) ==
				timer8_pkg::DIV64_MASK;
			timer8_pkg::CLK_DIV256: tick =
				(pre_reg & timer8_pkg::DIV256_MASK) == timer8_pkg::DIV256_MASK;
			timer8_pkg::CLK_DIV1024: tick =
				(pre_reg & timer8_pkg::DIV1024_MASK) ==
				timer8_pkg::DIV1024_MASK;
			timer8_pkg::CLK_EXT_FALL: tick = ext_sync_reg[2] && !ext_sync_reg[1];
			timer8_pkg::CLK_EXT_RISE: tick = !ext_sync_reg[2] && ext_sync_reg[1];
			default: tick = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Counting and waveform next state.
	logic [7:0] cnt_next;
	logic [7:0] act_next;
	logic dir_next;
	logic hit_next;
	logic out_next;
	logic ovf_set;
	logic match;
	logic at_max;
	logic at_bot;
	logic eff_up;

	assign is_pwm = ctrl_reg.wave_mode_sel == timer8_pkg::WAVE_PHASE ||
		ctrl_reg.wave_mode_sel == timer8_pkg::WAVE_FAST;
	assign at_max = count_value_reg == timer8_pkg::CNT_MAX;
	assign at_bot = count_value_reg == timer8_pkg::CNT_BOTTOM;
	assign match = count_value_reg == cmp_act_reg && !block_reg;
	// Bottom counts as up, top as down, so bottom compare stays low.
	// extreme compares
	assign eff_up = at_bot || (dir_up_reg && !at_max);

	always_comb begin
		cnt_next = count_value_reg + 8'h01;
		act_next = cmp_act_reg;
		dir_next = 1'b1;
		hit_next = up_hit_reg;
		out_next = cmp_out_bit;
		ovf_set = 1'b0;
		case (ctrl_reg.wave_mode_sel)
			timer8_pkg::WAVE_NORMAL: begin
				ovf_set = at_max;
				if (match) begin
					out_next = wave_action(cmp_out_bit, ctrl_reg.cmp_out_mode,
						ctrl_reg.wave_mode_sel, 1'b1);
				end
			end
			timer8_pkg::WAVE_CTC: begin
				if (match) begin
					cnt_next = timer8_pkg::CNT_BOTTOM;
				end
				ovf_set = at_max;
				if (match) begin
					out_next = wave_action(cmp_out_bit, ctrl_reg.cmp_out_mode,
						ctrl_reg.wave_mode_sel, 1'b1);
				end
			end
			timer8_pkg::WAVE_FAST: begin
				ovf_set = at_max;
				if (match && !(cmp_act_reg == timer8_pkg::CNT_MAX &&
						ctrl_reg.cmp_out_mode[1])) begin
					out_next = wave_action(cmp_out_bit, ctrl_reg.cmp_out_mode,
						ctrl_reg.wave_mode_sel, 1'b1);
				end
				if (at_max && ctrl_reg.cmp_out_mode[1]) begin
					out_next = !ctrl_reg.cmp_out_mode[0];
				end
				if (at_max) begin
					act_next = cmp_value_reg;
				end
			end
			timer8_pkg::WAVE_PHASE: begin
				if (dir_up_reg) begin
					cnt_next = at_max ? count_value_reg - 8'h01 :
						count_value_reg + 8'h01;
					dir_next = !at_max;
				end else begin
					cnt_next = at_bot ? count_value_reg + 8'h01 :
						count_value_reg - 8'h01;
					dir_next = at_bot;
				end
				ovf_set = at_bot && !dir_up_reg;
				if (match && !(cmp_act_reg == timer8_pkg::CNT_MAX &&
						ctrl_reg.cmp_out_mode[1])) begin
					out_next = wave_action(cmp_out_bit, ctrl_reg.cmp_out_mode,
						ctrl_reg.wave_mode_sel, eff_up);
					if (eff_up) begin
						hit_next = 1'b1;
					end
				end
				if (at_max) begin
					act_next = cmp_value_reg;
					hit_next = 1'b0;
					if (ctrl_reg.cmp_out_mode[1]) begin
						if (cmp_value_reg == timer8_pkg::CNT_MAX) begin
							out_next = !ctrl_reg.cmp_out_mode[0];
						end else if (!up_hit_reg) begin
							out_next = ctrl_reg.cmp_out_mode[0];
						end
					end
				end
			end
			default: cnt_next = count_value_reg;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Counter. A software load wins over any count and blocks one match.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			count_value_reg <= timer8_pkg::CNT_RESET;
			dir_up_reg <= 1'b1;
			up_hit_reg <= 1'b0;
		end else if (wr_count) begin
			count_value_reg <= w_data_reg[7:0];
		end else if (tick) begin
			count_value_reg <= cnt_next;
			dir_up_reg <= dir_next;
			up_hit_reg <= hit_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			block_reg <= 1'b0;
		end else if (wr_count) begin
			block_reg <= 1'b1;
		end else if (tick) begin
			block_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmp_value_reg <= timer8_pkg::CMP_RESET;
			cmp_act_reg <= timer8_pkg::CMP_RESET;
		end else begin
			if (wr_cmp) begin
				cmp_value_reg <= w_data_reg[7:0];
			end
			if (!is_pwm) begin
				cmp_act_reg <= wr_cmp ? w_data_reg[7:0] : cmp_value_reg;
			end else if (tick && !wr_count) begin
				cmp_act_reg <= act_next;
			end
		end
	end

	// Flags: a hardware set in the clearing cycle wins.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			overflow_flag <= 1'b0;
			cmp_match_flag <= 1'b0;
		end else begin
			if (tick && !wr_count && ovf_set) begin
				overflow_flag <= 1'b1;
			end else if (wr_stat && w_data_reg[timer8_pkg::STAT_OVF_BIT]) begin
				overflow_flag <= 1'b0;
			end
			if (tick && !wr_count && match) begin
				cmp_match_flag <= 1'b1;
			end else if (wr_stat && w_data_reg[timer8_pkg::STAT_CMP_BIT]) begin
				cmp_match_flag <= 1'b0;
			end
		end
	end

	// The force acts with the output mode written alongside it.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmp_out_bit <= 1'b0;
		end else if (force_cmp_strobe && !is_pwm) begin
			cmp_out_bit <= wave_action(cmp_out_bit,
				w_data_reg[timer8_pkg::CTRL_COM_LSB +: 2],
				ctrl_reg.wave_mode_sel, 1'b1);
		end else if (tick && !wr_count) begin
			cmp_out_bit <= out_next;
		end
	end

	assign cmp_out_pin = cmp_out_bit;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmp_out_en <= 1'b0;
		end else begin
			cmp_out_en <= ctrl_reg.cmp_out_mode != 2'b00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_NORMAL_WRAP: assert property (
		tick && !wr_count && at_max &&
		ctrl_reg.wave_mode_sel == timer8_pkg::WAVE_NORMAL
		|=> count_value_reg == 8'h00 && overflow_flag)
		else $error("normal mode wrap or overflow wrong");
	AST_CTC_CLEAR: assert property (
		tick && !wr_count && match &&
		ctrl_reg.wave_mode_sel == timer8_pkg::WAVE_CTC
		|=> count_value_reg == 8'h00)
		else $error("compare clear did not clear counter");
	AST_CMP_FLAG: assert property (
		tick && !wr_count && match |=> cmp_match_flag)
		else $error("compare flag not set after match");
	AST_COM0_HOLD: assert property (
		ctrl_reg.cmp_out_mode == 2'b00 && !force_cmp_strobe
		|=> $stable(cmp_out_bit))
		else $error("output moved with output mode zero");
	AST_PC_TOP: assert property (
		tick && !wr_count && at_max &&
		ctrl_reg.wave_mode_sel == timer8_pkg::WAVE_PHASE
		|=> count_value_reg == 8'hFE)
		else $error("phase mode did not turn at top");
	AST_FAST_WRAP_SET: assert property (
		tick && !wr_count && at_max && ctrl_reg.cmp_out_mode == 2'b10 &&
		ctrl_reg.wave_mode_sel == timer8_pkg::WAVE_FAST
		|=> cmp_out_bit && count_value_reg == 8'h00)
		else $error("fast PWM output not set at wrap");
	AST_NO_TICK: assert property (
		!tick && !wr_count |=> $stable(count_value_reg))
		else $error("counter moved without a tick");
	AST_PC_OVF: assert property (
		tick && !wr_count && at_bot && !dir_up_reg &&
		ctrl_reg.wave_mode_sel == timer8_pkg::WAVE_PHASE
		|=> overflow_flag && count_value_reg == 8'h01)
		else $error("phase mode overflow missing at bottom");
	AST_FORCE_NOFLAG: assert property (
		force_cmp_strobe && !tick && !cmp_match_flag
		|=> !cmp_match_flag && $stable(count_value_reg))
		else $error("force changed flag or counter");

	COV_FAST_WRAP: cover property (tick && at_max &&
		ctrl_reg.wave_mode_sel == timer8_pkg::WAVE_FAST);
	COV_PC_BOTTOM: cover property (tick && at_bot && !dir_up_reg);
	COV_CTC_TOGGLE: cover property (tick && match &&
		ctrl_reg.wave_mode_sel == timer8_pkg::WAVE_CTC &&
		ctrl_reg.cmp_out_mode == 2'b01);

endmodule

// [pkg/timer8_pkg.sv]
// Purpose: Shared constants and types for the 8-bit waveform timer.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes: Register offsets are byte addresses.
package timer8_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map.
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_COUNT = 4'h4;
	localparam logic [3:0] OFS_CMP = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;

	// Control register field positions.
	localparam int CTRL_WAVE_LSB = 0;
	localparam int CTRL_COM_LSB = 2;
	localparam int CTRL_CLK_LSB = 4;
	localparam int CTRL_FORCE_BIT = 7;

	// Status register field positions.
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_CMP_BIT = 1;
	localparam int STAT_OUT_BIT = 2;

	////////////////////////////////////////////////////////////////////////
	// Values.
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Prescale divide masks: tick when the low prescaler bits are all ones.
	localparam logic [9:0] DIV8_MASK = 10'h007;
	localparam logic [9:0] DIV64_MASK = 10'h03F;
	localparam logic [9:0] DIV256_MASK = 10'h0FF;
	localparam logic [9:0] DIV1024_MASK = 10'h3FF;

	////////////////////////////////////////////////////////////////////////
	// Types.
	typedef enum logic [1:0] {
		WAVE_NORMAL = 2'h0,
		WAVE_PHASE = 2'h1,
		WAVE_CTC = 2'h2,
		WAVE_FAST = 2'h3
	} wave_mode_t;

	typedef enum logic [2:0] {
		CLK_STOP = 3'h0,
		CLK_DIV1 = 3'h1,
		CLK_DIV8 = 3'h2,
		CLK_DIV64 = 3'h3,
		CLK_DIV256 = 3'h4,
		CLK_DIV1024 = 3'h5,
		CLK_EXT_FALL = 3'h6,
		CLK_EXT_RISE = 3'h7
	} clk_sel_t;

	typedef struct packed {
		clk_sel_t clk_sel;
		logic [1:0] cmp_out_mode;
		wave_mode_t wave_mode_sel;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{CLK_STOP, 2'b00, WAVE_NORMAL};

endpackage

// [dv/timer8_wave_tb.sv]
// Purpose: Self-checking bench for the 8-bit waveform timer.
// Assumes: Ticks come from the count pin in rising-edge mode, except in the prescale test.
// Notes: Pin stepping puts every tick at a known point, so the model
// can be compared after each tick without guessing internal latency.
`timescale 1ns/1ps

module timer8_wave_tb;

	////////////////////////////////////////////////////////////////////////
	localparam logic [31:0] A_CTRL = 32'(timer8_pkg::OFS_CTRL);
	localparam logic [31:0] A_CNT = 32'(timer8_pkg::OFS_COUNT);
	localparam logic [31:0] A_CMP = 32'(timer8_pkg::OFS_CMP);
	localparam logic [31:0] A_ST = 32'(timer8_pkg::OFS_STATUS);
	localparam logic [1:0] OK = timer8_pkg::RESP_OKAY;
	localparam logic [1:0] BAD = timer8_pkg::RESP_SLVERR;
	logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, pin;
	logic awready, wready, bvalid, arready, rvalid, opin, oen, ovf, cmf;
	logic [31:0] awaddr, wdata, araddr, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int n_fail, samples_checked;
	int cnt, cmp, buff, mode, com, mo, mc, out, up, blk, upm;
	int fc[5] = '{3, 0, 2, 1, 1};
	int dvs[5] = '{1, 8, 64, 256, 1024};
	int cyc, wr_cyc;

	timer8_wave dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_count_pin(pin), .cmp_out_pin(opin),
		.cmp_out_en(oen), .overflow_flag(ovf), .cmp_match_flag(cmf));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Clocks since reset, to know where the free-running prescaler stands.
	always @(posedge clk) begin
		if (!rstn)
			cyc <= 0;
		else
			cyc <= cyc + 1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string w, input logic [31:0] e,
			input logic [31:0] g);
		samples_checked++;
		if (e !== g) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d,
			input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		wr_cyc = cyc;
		chk("bresp", 32'(er), 32'(bresp));
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdr(input logic [31:0] a, output logic [31:0] d,
			input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		chk("rresp", 32'(er), 32'(rresp));
		rready <= 1'b0;
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic act();
		if (com == 1) out = !out;
		else if (com >= 2) out = (com == 3);
	endtask

	task automatic step();
		int n;
		bit m;
		m = (cnt == cmp) && !blk;
		blk = 0;
		if (m) mc = 1;
		n = (cnt + 1) % 256;
		if (mode % 2 == 0) begin
			if (mode == 2 && m) n = 0;
			if (cnt == 255) mo = 1;
			if (m) act();
		end else if (mode == 3) begin
			if (m && !(cmp == 255 && com >= 2)) act();
			if (cnt == 255) begin
				mo = 1;
				cmp = buff;
				if (com >= 2) out = (com == 2);
			end
		end else if (cnt == 255) begin
			n = 254;
			up = 0;
			cmp = buff;
			if (com >= 2 && cmp == 255) out = (com == 2);
			else if (com >= 2 && !upm) out = (com == 3);
		end else if (up || cnt == 0) begin
			if (!up) begin
				mo = 1;
				upm = 0;
			end
			if (m && com >= 2) begin
				out = (com == 3);
				upm = 1;
			end
			up = 1;
		end else begin
			if (m && com >= 2) out = (com == 2);
			n = cnt - 1;
		end
		cnt = n;
	endtask

	task automatic wctrl(input int k, input int c, input int m, input int f);
		mode = m;
		com = c;
		if (m % 2 == 0) cmp = buff;
		if (f && m % 2 == 0) act();
		wr(A_CTRL, 32'((k << timer8_pkg::CTRL_CLK_LSB) | m |
			(c << timer8_pkg::CTRL_COM_LSB) |
			(f << timer8_pkg::CTRL_FORCE_BIT)), OK);
	endtask

	task automatic wcmp(input int v);
		buff = v;
		if (mode % 2 == 0) cmp = v;
		wr(A_CMP, 32'(v), OK);
	endtask

	task automatic look();
		rdr(A_CNT, rd, OK);
		chk("count", 32'(cnt), rd);
		rdr(A_ST, rd, OK);
		chk("status", 32'({out[0], mc[0], mo[0]}), rd);
		chk("out_pin", 32'(out), 32'(opin));
		chk("out_en", 32'(com != 0), 32'(oen));
		chk("cmp_flag", 32'(mc), 32'(cmf));
	endtask

	task automatic pulse();
		pin <= 1'b1;
		repeat (6) @(posedge clk);
		pin <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			pulse();
			step();
			look();
		end
	endtask

	task automatic setup(input int m, input int c, input int c0, input int v);
		wctrl(0, c, 0, 0);
		wcmp(v);
		cnt = c0;
		blk = 1;
		wr(A_CNT, 32'(c0), OK);
		wr(A_ST, 32'h0000_0003, OK);
		mo = 0;
		mc = 0;
		wctrl(7, c, m, 0);
	endtask

	task automatic end_test(input string s);
		rdr(A_ST, rd, OK);
		chk("flags", 32'({out[0], mc[0], mo[0]}), rd);
		chk("ovf_port", 32'(mo), 32'(ovf));
		$display("test %s done", s);
	endtask

	task automatic reset_dut();
		rstn <= 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		{cnt, cmp, buff, mode, com, mo, mc, out, blk, upm} = 0;
		up = 1;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		$display("[ERR] watchdog expected finish seen timeout");
		finish_test();
	end

	initial begin
		int n, s;
		{rstn, awvalid, wvalid, bready, arvalid, rready, pin} = 0;
		{awaddr, wdata, araddr, wstrb} = 0;
		void'($urandom(32'hd6b0));
		reset_dut();
		for (int i = 0; i < 4; i++) begin
			rdr(32'(i * 4), rd, OK);
			chk("reset_reg", 32'h0000_0000, rd);
		end
		wr(32'h0000_0010, 32'h0000_0001, BAD);
		rdr(32'h0000_0010, rd, BAD);
		$display("test reset_map done");
		foreach (fc[i]) begin
			wctrl(0, fc[i], 0, 1);
			look();
		end
		rdr(A_CTRL, rd, OK);
		chk("ctrl", 32'h0000_0004, rd);
		pulse();
		look();
		end_test("force");
		// A tick falls on each clock whose prescaler low bits are all ones.
		foreach (dvs[i]) begin
			setup(0, 0, 0, 0);
			wctrl(i + 1, 0, 0, 0);
			s = wr_cyc;
			repeat (dvs[i] + $urandom_range(99, 0)) @(posedge clk);
			wctrl(0, 0, 0, 0);
			n = 0;
			for (int p = s; p < wr_cyc; p++)
				n += (p % dvs[i] == dvs[i] - 1);
			rdr(A_CNT, rd, OK);
			chk("prescale", 32'(n % 256), rd);
		end
		wctrl(6, 0, 0, 0);
		pulse();
		rdr(A_CNT, rd, OK);
		chk("fall_edge", 32'((n + 1) % 256), rd);
		$display("test prescale done");
		setup(0, 1, 'hfc, 'hfe);
		ticks(6);
		end_test("normal");
		setup(0, 0, 'h10, 'h12);
		ticks(4);
		end_test("normal_off");
		setup(2, 1, 0, $urandom_range(9, 2));
		ticks(25);
		end_test("ctc_random");
		setup(2, 1, 20, 5);
		ticks(245);
		end_test("ctc_low_top");
		setup(2, 1, 0, 2);
		ticks(3);
		wcmp(0);
		ticks(6);
		end_test("ctc_zero");
		for (int c = 1; c < 4; c++) begin
			setup(3, c, 'hf8, 'hfc);
			ticks(14);
			end_test("fast_modes");
		end
		setup(3, 2, 'hf8, 0);
		ticks(12);
		setup(3, 3, 'hf8, 'hff);
		ticks(12);
		end_test("fast_extremes");
		setup(3, 2, 'hf0, 'hf8);
		ticks(4);
		wcmp('hf2);
		ticks(24);
		end_test("fast_buffer");
		reset_dut();
		setup(1, 2, 5, 3);
		ticks(515);
		end_test("phase_full");
		reset_dut();
		setup(1, 3, 'hf0, 'hf8);
		ticks(30);
		end_test("phase_inv");
		reset_dut();
		setup(1, 2, 'hf0, 0);
		ticks(30);
		reset_dut();
		setup(1, 2, 'hf0, 'hff);
		ticks(30);
		end_test("phase_extremes");
		finish_test();
	end

endmodule
